// file: inc/aic_params.svh
/*
 constants of the analog input conditioning block: limits, scales, codes.
 assumes inclusion by bare name from the design files.
*/
`ifndef AIC_PARAMS_SVH
`define AIC_PARAMS_SVH
`define AIC_FIFO_DEPTH 16
`define AIC_FRAC 8
`define AIC_OFS1_LIM 14'sh15CA
`define AIC_OFS23_LIM 14'sh0156
`define AIC_OFS_RST 14'sh0000
`define AIC_LSB1_UV 32'h0000_0167
`define AIC_LSB23_UV 32'h0000_16E4
`define AIC_LEVEL_UV 32'h0001_86A0
`define AIC_TS_CMS 14'h0001
`define AIC_MON_FS_MV 17'sh02710
`define AIC_MON_MID_MV 17'sh01388
`define AIC_MON_RST 15'sh0000
`define AIC_ALARM_EXCESS 8'h27
`define AIC_ALARM_NONE 8'h00
`define AIC_RNG_BIPOLAR 2'h0
`define AIC_RNG_ABS 2'h1
`define AIC_RNG_MID 2'h2
`endif

// file: inc/aic_pkg.sv
/*
 types of the analog input conditioning block.
 assumes nothing of its surroundings.
*/
package aic_pkg;
	typedef logic signed [15:0] aic_sample_t;
	typedef logic signed [13:0] aic_offset_t;
	typedef logic [12:0] aic_tc_t;
	typedef logic [6:0] aic_level_t;
	typedef logic [1:0] aic_chan_t;
	typedef logic [1:0] aic_range_t;
	typedef logic signed [14:0] aic_mv_t;
	typedef logic signed [23:0] aic_acc_t;
	typedef struct packed {
		aic_chan_t ch;
		aic_sample_t data;
	} aic_word_t;
	typedef enum logic {AIC_IDLE, AIC_ARMED} aic_adj_state_t;
endpackage

// file: inc/aic_fifo_if.sv
/*
 fifo carrier between the conditioning top and its sample buffer.
 assumes one clock shared by both ends.
*/
`timescale 1ns/1ns
`default_nettype none
interface aic_fifo_if #(parameter int W = 18) ();
	logic wr_valid;
	logic wr_ready;
	logic [W-1:0] wr_data;
	logic rd_valid;
	logic rd_ready;
	logic [W-1:0] rd_data;
	modport fill (output wr_valid, output wr_data, input wr_ready);
	modport drain (input rd_valid, input rd_data, output rd_ready);
	modport fifo (input wr_valid, input wr_data, output wr_ready,
		output rd_valid, output rd_data, input rd_ready);
endinterface
`default_nettype wire

// file: core/aic_fifo.sv
/*
 sample buffer with valid/ready on both sides.
 assumes DEPTH is a power of two and a synchronous active high reset.
*/
`timescale 1ns/1ns
`default_nettype none
module aic_fifo #(
	parameter int WIDTH = 18,
	parameter int DEPTH = 16
) (
	input wire logic clk,
	input wire logic rst,
	aic_fifo_if.fifo port
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wp_ff;
	logic [AW-1:0] rp_ff;
	logic [AW:0] cnt_ff;
	logic [AW-1:0] nxt_wp;
	logic [AW-1:0] nxt_rp;
	logic [AW:0] nxt_cnt;
	logic push;
	logic pop;

	assign port.wr_ready = (cnt_ff != (AW+1)'(DEPTH));
	assign port.rd_valid = (cnt_ff != '0);
	assign port.rd_data = mem[rp_ff];
	assign push = port.wr_valid && port.wr_ready;
	assign pop = port.rd_valid && port.rd_ready;

	always_comb begin
		nxt_wp = push ? wp_ff + 1'b1 : wp_ff;
		nxt_rp = pop ? rp_ff + 1'b1 : rp_ff;
		nxt_cnt = cnt_ff + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			wp_ff <= '0;
			rp_ff <= '0;
			cnt_ff <= '0;
		end else begin
			wp_ff <= nxt_wp;
			rp_ff <= nxt_rp;
			cnt_ff <= nxt_cnt;
		end
	end

	always_ff @(posedge clk) begin
		if (push) begin
			mem[wp_ff] <= port.wr_data;
		end
	end
endmodule
`default_nettype wire

// file: core/aic_top.sv
/*
 analog input conditioning: offset, lag filter, overflow alarm, monitor range.
 assumes samples arrive from same-clock converter logic, one channel per word.
*/
// Summary of operation
// RULE1: monitor range 0 gives -10..10 V, settings 1 and 2 give 0..10 V.
// RULE2: range 2 puts zero at 5 V, spreading symmetrically to 10 V and 0 V.
// RULE3: input 1 offset is signed -5578..5578, about 0.359 mV per step.
// RULE4: input 2 offset is signed -342..342, about 5.86 mV per step.
// RULE5: input 3 offset is signed -342..342, default zero, applied before processing.
// RULE6: each input has a first-order lag, time constant 0..6400 of 0.01 ms.
// RULE7: each input has an overflow level 0..100 in 0.1 V steps.
// RULE8: overflow compares the offset-compensated voltage, not the raw sample.
// RULE9: overflow raises alarm 39; a zero level disables that alarm.
// RULE10: automatic adjustment computes and writes the offsets itself.
// RULE11: for manual calibration the host holds the input at exactly 0 V.
// RULE12: monitor range 0..2 sets polarity and direction of the monitor voltage.
`include "aic_params.svh"
`timescale 1ns/1ns
`default_nettype none
module aic_top (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic in_valid,
	output logic in_ready,
	input wire aic_pkg::aic_chan_t in_chan,
	input wire aic_pkg::aic_sample_t in_sample,
	input wire aic_pkg::aic_offset_t input1_offset,
	input wire aic_pkg::aic_offset_t input2_offset,
	input wire aic_pkg::aic_offset_t input3_offset,
	input wire logic offset_wr,
	input wire logic auto_adj_start,
	output logic auto_adj_busy,
	output logic auto_adj_done,
	output aic_pkg::aic_offset_t input1_offset_now,
	output aic_pkg::aic_offset_t input2_offset_now,
	output aic_pkg::aic_offset_t input3_offset_now,
	input wire aic_pkg::aic_tc_t input1_filter_tc,
	input wire aic_pkg::aic_tc_t input2_filter_tc,
	input wire aic_pkg::aic_tc_t input3_filter_tc,
	input wire aic_pkg::aic_level_t input1_overflow_level,
	input wire aic_pkg::aic_level_t input2_overflow_level,
	input wire aic_pkg::aic_level_t input3_overflow_level,
	input wire logic alarm_clear,
	output logic [2:0] alarm_flags,
	output logic [7:0] alarm_code,
	output logic out_valid,
	input wire logic out_ready,
	output aic_pkg::aic_chan_t out_chan,
	output aic_pkg::aic_sample_t force_command_input,
	input wire aic_pkg::aic_range_t monitor_output_range_sel,
	input wire aic_pkg::aic_mv_t monitor_value_mv,
	output aic_pkg::aic_mv_t monitor_out_mv
);
	import aic_pkg::*;

	function automatic aic_offset_t clamp_ofs(input logic signed [16:0] v, input aic_offset_t lim);
		if (v > lim) return lim;
		if (v < -lim) return -lim;
		return v[13:0];
	endfunction

	function automatic aic_acc_t filt_step(input aic_acc_t y, input aic_sample_t x, input aic_tc_t tc);
		logic signed [23:0] xs;
		logic signed [24:0] d;
		logic signed [39:0] num;
		logic signed [39:0] den;
		logic signed [39:0] q;
		xs = {x, 8'h00};
		d = {xs[23], xs} - {y[23], y};
		num = $signed({{15{d[24]}}, d}) * $signed({26'h0, `AIC_TS_CMS});
		den = $signed({27'h0, tc}) + $signed({26'h0, `AIC_TS_CMS});
		q = num / den;
		if (tc == '0) return xs;
		return y + q[23:0];
	endfunction

	aic_fifo_if #(.W($bits(aic_word_t))) fif ();
	aic_fifo #(.WIDTH($bits(aic_word_t)), .DEPTH(`AIC_FIFO_DEPTH)) u_fifo (
		.clk(core_clk),
		.rst(rst),
		.port(fif.fifo)
	);

	aic_word_t w;
	logic pop;
	logic chan_ok;
	aic_chan_t ci;
	logic [2:0] hitv;
	aic_offset_t ofs_in [3];
	aic_offset_t lim [3];
	aic_tc_t tc [3];
	aic_level_t lvl [3];
	logic [31:0] lsb [3];
	aic_offset_t ofs_ff [3];
	aic_offset_t nxt_ofs [3];
	aic_acc_t y_ff [3];
	aic_acc_t nxt_y [3];
	logic [2:0] alarm_ff;
	logic [2:0] nxt_alarm;
	logic signed [16:0] comp;
	aic_sample_t comp_sat;
	logic [16:0] mag;
	logic over;

	assign fif.wr_valid = in_valid;
	assign fif.wr_data = {in_chan, in_sample};
	assign in_ready = fif.wr_ready;
	assign fif.rd_ready = !out_valid || out_ready;
	assign w = fif.rd_data;
	assign pop = fif.rd_valid && fif.rd_ready;
	assign chan_ok = (w.ch != 2'h3);
	assign ci = chan_ok ? w.ch : 2'h0;
	assign hitv = (pop && chan_ok) ? (3'h1 << w.ch) : 3'h0;
	assign ofs_in[0] = input1_offset;
	assign ofs_in[1] = input2_offset;
	assign ofs_in[2] = input3_offset;
	assign lim[0] = `AIC_OFS1_LIM; // RULE3
	assign lim[1] = `AIC_OFS23_LIM; // RULE4
	assign lim[2] = `AIC_OFS23_LIM; // RULE5
	assign lsb[0] = `AIC_LSB1_UV;
	assign lsb[1] = `AIC_LSB23_UV;
	assign lsb[2] = `AIC_LSB23_UV;
	assign tc[0] = input1_filter_tc;
	assign tc[1] = input2_filter_tc;
	assign tc[2] = input3_filter_tc;
	assign lvl[0] = input1_overflow_level;
	assign lvl[1] = input2_overflow_level;
	assign lvl[2] = input3_overflow_level;
	assign input1_offset_now = ofs_ff[0];
	assign input2_offset_now = ofs_ff[1];
	assign input3_offset_now = ofs_ff[2];
	assign alarm_flags = alarm_ff;

	// offset compensation and overflow compare on the selected channel
	always_comb begin
		comp = $signed({w.data[15], w.data}) - $signed({{3{ofs_ff[ci][13]}}, ofs_ff[ci]}); // RULE5
		if (comp > 17'sh07FFF) comp_sat = 16'sh7FFF;
		else if (comp < -17'sh08000) comp_sat = 16'sh8000;
		else comp_sat = comp[15:0];
		mag = comp[16] ? 17'(-comp) : 17'(comp); // RULE8
		over = (lvl[ci] != '0) && (32'(mag) * lsb[ci] > 32'(lvl[ci]) * `AIC_LEVEL_UV); // RULE7
	end

	// auto offset adjustment sequencer
	aic_adj_state_t st_ff;
	aic_adj_state_t nxt_st;
	logic [2:0] pend_ff;
	logic [2:0] nxt_pend;
	logic done_ff;
	logic nxt_done;

	assign auto_adj_busy = (st_ff == AIC_ARMED);
	assign auto_adj_done = done_ff;

	always_comb begin
		nxt_st = st_ff;
		nxt_pend = pend_ff;
		nxt_done = 1'b0;
		case (st_ff)
			AIC_IDLE: begin
				if (auto_adj_start) begin
					nxt_st = AIC_ARMED;
					nxt_pend = 3'h7;
				end
			end
			AIC_ARMED: begin
				nxt_pend = pend_ff & ~hitv;
				if (nxt_pend == 3'h0) begin
					nxt_st = AIC_IDLE;
					nxt_done = 1'b1;
				end
			end
			default: begin
				nxt_st = AIC_IDLE;
				nxt_pend = 3'h0;
			end
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			st_ff <= AIC_IDLE;
			pend_ff <= 3'h0;
			done_ff <= 1'b0;
		end else begin
			st_ff <= nxt_st;
			pend_ff <= nxt_pend;
			done_ff <= nxt_done;
		end
	end

	// per-channel offset, filter state and sticky alarm
	for (genvar g = 0; g < 3; g++) begin : g_ch
		always_comb begin
			nxt_ofs[g] = ofs_ff[g];
			if (auto_adj_busy && pend_ff[g] && hitv[g]) begin
				nxt_ofs[g] = clamp_ofs({w.data[15], w.data}, lim[g]); // RULE10
			end else if (offset_wr && !auto_adj_busy) begin
				nxt_ofs[g] = clamp_ofs(17'(ofs_in[g]), lim[g]); // RULE3
			end
			nxt_y[g] = hitv[g] ? filt_step(y_ff[g], comp_sat, tc[g]) : y_ff[g]; // RULE6
			nxt_alarm[g] = (alarm_ff[g] && !alarm_clear) || (hitv[g] && over); // RULE9
		end

		always_ff @(posedge core_clk) begin
			if (rst) begin
				ofs_ff[g] <= `AIC_OFS_RST;
				y_ff[g] <= '0;
				alarm_ff[g] <= 1'b0;
			end else begin
				ofs_ff[g] <= nxt_ofs[g];
				y_ff[g] <= nxt_y[g];
				alarm_ff[g] <= nxt_alarm[g];
			end
		end
	end

	// filtered output stream and alarm code
	logic out_valid_ff;
	logic nxt_out_valid;
	aic_chan_t out_chan_ff;
	aic_chan_t nxt_out_chan;
	aic_sample_t out_filt_ff;
	aic_sample_t nxt_out_filt;
	logic [7:0] code_ff;
	logic [7:0] nxt_code;

	assign out_valid = out_valid_ff;
	assign out_chan = out_chan_ff;
	assign force_command_input = out_filt_ff;
	assign alarm_code = code_ff;

	always_comb begin
		nxt_out_valid = out_valid_ff && !out_ready;
		nxt_out_chan = out_chan_ff;
		nxt_out_filt = out_filt_ff;
		if (pop && chan_ok) begin
			nxt_out_valid = 1'b1;
			nxt_out_chan = w.ch;
			nxt_out_filt = nxt_y[ci][23:8];
		end
		nxt_code = (nxt_alarm != 3'h0) ? `AIC_ALARM_EXCESS : `AIC_ALARM_NONE; // RULE9
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			out_valid_ff <= 1'b0;
			out_chan_ff <= 2'h0;
			out_filt_ff <= 16'sh0000;
			code_ff <= `AIC_ALARM_NONE;
		end else begin
			out_valid_ff <= nxt_out_valid;
			out_chan_ff <= nxt_out_chan;
			out_filt_ff <= nxt_out_filt;
			code_ff <= nxt_code;
		end
	end

	// monitor output range mapping
	aic_mv_t mon_ff;
	aic_mv_t nxt_mon;
	logic signed [16:0] mv;
	logic signed [16:0] mlo;

	assign monitor_out_mv = mon_ff;

	always_comb begin
		mv = 17'(monitor_value_mv);
		mlo = -`AIC_MON_FS_MV;
		case (monitor_output_range_sel)
			`AIC_RNG_ABS: begin
				mv = mv[16] ? -mv : mv; // RULE12
				mlo = 17'sh00000; // RULE1
			end
			`AIC_RNG_MID: begin
				mv = `AIC_MON_MID_MV + (mv >>> 1); // RULE2
				mlo = 17'sh00000;
			end
			default: begin
				mv = mv; // RULE1
			end
		endcase
		if (mv > `AIC_MON_FS_MV) mv = `AIC_MON_FS_MV;
		else if (mv < mlo) mv = mlo;
		nxt_mon = mv[14:0];
	end

	always_ff @(posedge core_clk) begin
		if (rst) mon_ff <= `AIC_MON_RST;
		else mon_ff <= nxt_mon;
	end

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);

	property p_bipolar;
		monitor_output_range_sel == 2'h0 && monitor_value_mv <= 15'sh2710
			&& monitor_value_mv >= -15'sh2710 |=> monitor_out_mv == $past(monitor_value_mv);
	endproperty
	a_bipolar: assert property (p_bipolar) else $error("bipolar monitor mismatch"); // RULE1
	property p_unipolar;
		monitor_output_range_sel inside {2'h1, 2'h2} |=> monitor_out_mv >= 15'sh0000;
	endproperty
	a_unipolar: assert property (p_unipolar) else $error("unipolar monitor negative"); // RULE1
	property p_mid;
		monitor_output_range_sel == 2'h2 && monitor_value_mv == 15'sh0000 |=> monitor_out_mv == 15'sh1388;
	endproperty
	a_mid: assert property (p_mid) else $error("mid-scale not 5 V"); // RULE2
	property p_abs;
		monitor_output_range_sel == 2'h1 && monitor_value_mv < 15'sh0000
			&& monitor_value_mv > -15'sh2710 |=> monitor_out_mv == -$past(monitor_value_mv);
	endproperty
	a_abs: assert property (p_abs) else $error("abs monitor mismatch"); // RULE12
	property p_ofs1;
		input1_offset_now <= 14'sh15CA && input1_offset_now >= -14'sh15CA;
	endproperty
	a_ofs1: assert property (p_ofs1) else $error("offset 1 out of range"); // RULE3
	property p_ofs2;
		input2_offset_now <= 14'sh0156 && input2_offset_now >= -14'sh0156;
	endproperty
	a_ofs2: assert property (p_ofs2) else $error("offset 2 out of range"); // RULE4
	property p_ofs3;
		input3_offset_now <= 14'sh0156 && input3_offset_now >= -14'sh0156;
	endproperty
	a_ofs3: assert property (p_ofs3) else $error("offset 3 out of range"); // RULE5
	property p_bypass;
		hitv[0] && input1_filter_tc == '0 |=> out_valid && out_chan == 2'h0
			&& force_command_input == $past(comp_sat);
	endproperty
	a_bypass: assert property (p_bypass) else $error("zero time constant not bypass"); // RULE6
	property p_over;
		hitv[0] && input1_overflow_level != '0 && over |=> alarm_flags[0] && alarm_code == 8'h27;
	endproperty
	a_over: assert property (p_over) else $error("overflow did not raise alarm"); // RULE7
	property p_comp;
		hitv[0] && comp == 17'sh00000 && !alarm_flags[0] |=> !alarm_flags[0];
	endproperty
	a_comp: assert property (p_comp) else $error("alarm on compensated zero"); // RULE8
	property p_off;
		input1_overflow_level == '0 && !alarm_flags[0] |=> !alarm_flags[0];
	endproperty
	a_off: assert property (p_off) else $error("alarm with zero level"); // RULE9
	property p_auto;
		auto_adj_busy && pend_ff[0] && hitv[0] && w.data <= 16'sh15CA && w.data >= -16'sh15CA
			|=> input1_offset_now == $past(w.data[13:0]);
	endproperty
	a_auto: assert property (p_auto) else $error("auto offset not written"); // RULE10
	c_alarm: cover property (hitv[1] && over);
	c_auto_done: cover property (auto_adj_done);
	c_full: cover property (in_valid && !in_ready);
endmodule
`default_nettype wire

// file: verif/aic_host_model.sv
/*
 host controller model: offers one channel sample at a time on valid/ready.
 assumes one clock; the bench calls send and idle just after a rising edge.
*/
`timescale 1ns/1ns
`default_nettype none
module aic_host_model (
	input wire logic core_clk,
	input wire logic slow,
	input wire logic in_ready,
	output logic in_valid,
	output aic_pkg::aic_chan_t in_chan,
	output aic_pkg::aic_sample_t in_sample
);
	import aic_pkg::*;
	initial begin
		in_valid = 1'b0;
		in_chan = 2'h0;
		in_sample = 16'sh0000;
	end
	// holds the word until the edge that sees ready; slow mode idles first
	task automatic send(input aic_chan_t ch, input aic_sample_t s);
		bit ok;
		if (slow) begin
			in_valid <= 1'b0;
			in_sample <= ~in_sample;
			repeat ($urandom_range(1, 3)) @(posedge core_clk);
		end
		in_valid <= 1'b1;
		in_chan <= ch;
		in_sample <= s;
		do begin
			@(negedge core_clk);
			ok = in_ready;
			@(posedge core_clk);
		end while (!ok);
	endtask
	// released data line shows no stale value
	task automatic idle();
		in_valid <= 1'b0;
		in_sample <= ~in_sample;
	endtask
endmodule
`default_nettype wire

// file: verif/testbench.sv
/*
 self-checking bench: monitor map, offsets, lag filter, buffer, alarm, auto adjust.
 assumes the host model drives the sample input of the conditioning top.
*/
`include "aic_params.svh"
`timescale 1ns/1ns
`default_nettype none
module testbench;
	import aic_pkg::*;
	logic core_clk = 1'b0, rst = 1'b1, slow = 1'b0, stall = 1'b1, out_ready = 1'b0;
	logic in_valid, in_ready, out_valid, auto_adj_busy, auto_adj_done;
	logic offset_wr = 1'b0, auto_adj_start = 1'b0, alarm_clear = 1'b0;
	aic_chan_t in_chan, out_chan;
	aic_sample_t in_sample, fci;
	aic_range_t sel = 2'h0;
	aic_mv_t mon_in = '0, mon_out;
	aic_offset_t ofs [3] = '{'0, '0, '0};
	aic_offset_t now [3];
	aic_tc_t tc [3] = '{'0, '0, '0};
	aic_level_t lvl [3] = '{'0, '0, '0};
	logic [2:0] flags;
	logic [7:0] code;
	int errors = 0, num_checks = 0, cycles = 0, n;
	int cur [3] = '{0, 0, 0};
	int corner [10] = '{0, 1, -1, 9999, 10000, 10001, -10001, 16383, -16384, -9999};
	int atab [10][5] = '{'{1, 10, 0, 170, 0}, '{1, 10, 0, 171, 1}, '{1, 10, 100, 271, 1},
		'{1, 10, 100, 270, 0}, '{1, 0, 0, 30000, 0}, '{2, 100, 0, 1706, 0},
		'{2, 100, 0, 1707, 1}, '{2, 100, 0, -1707, 1}, '{0, 1, 0, 278, 0}, '{0, 1, 0, 279, 1}};
	logic [17:0] exp_q [$], got [$];
	aic_host_model host (.core_clk, .slow, .in_ready, .in_valid, .in_chan, .in_sample);
	aic_top uut (
		.core_clk, .rst, .in_valid, .in_ready, .in_chan, .in_sample,
		.input1_offset(ofs[0]), .input2_offset(ofs[1]), .input3_offset(ofs[2]),
		.offset_wr, .auto_adj_start, .auto_adj_busy, .auto_adj_done,
		.input1_offset_now(now[0]), .input2_offset_now(now[1]), .input3_offset_now(now[2]),
		.input1_filter_tc(tc[0]), .input2_filter_tc(tc[1]), .input3_filter_tc(tc[2]),
		.input1_overflow_level(lvl[0]), .input2_overflow_level(lvl[1]),
		.input3_overflow_level(lvl[2]), .alarm_clear, .alarm_flags(flags), .alarm_code(code),
		.out_valid, .out_ready, .out_chan, .force_command_input(fci),
		.monitor_output_range_sel(sel), .monitor_value_mv(mon_in), .monitor_out_mv(mon_out)
	);
	initial begin
		forever #4 core_clk = ~core_clk;
	end
	always @(posedge core_clk) begin
		out_ready <= stall ? 1'b0 : ($urandom_range(0, 3) != 0);
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			errors++;
			conclude();
		end
	end
	always @(negedge core_clk) begin
		if (!rst && out_valid === 1'b1 && out_ready === 1'b1)
			got.push_back({out_chan, fci});
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			errors++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic conclude();
		$display("checks=%0d errors=%0d", num_checks, errors);
		if (errors == 0 && num_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	function automatic int clampi(int v, int lo, int hi);
		return v < lo ? lo : (v > hi ? hi : v);
	endfunction
	function automatic int mon_exp(int r, int v);
		if (r == 1)
			return clampi(v < 0 ? -v : v, 0, 10000);
		if (r == 2)
			return clampi(5000 + (v >>> 1), 0, 10000);
		return clampi(v, -10000, 10000);
	endfunction
	task automatic write_ofs(input int a, input int b, input int c);
		int v [3] = '{a, b, c};
		@(posedge core_clk);
		for (int i = 0; i < 3; i++)
			ofs[i] <= 14'(v[i]);
		offset_wr <= 1'b1;
		@(posedge core_clk);
		offset_wr <= 1'b0;
		#1;
		for (int i = 0; i < 3; i++) begin
			cur[i] = clampi(v[i], i == 0 ? -5578 : -342, i == 0 ? 5578 : 342);
			check(now[i], cur[i]);
		end
	endtask
	task automatic put(input int ch, input int s);
		host.send(2'(ch), 16'(s));
		if (ch != 3)
			exp_q.push_back({2'(ch), 16'(s - cur[ch])});
	endtask
	task automatic drain();
		host.idle();
		for (n = 0; got.size() < exp_q.size() && n < 2000; n++)
			@(posedge core_clk);
		check(got.size(), exp_q.size());
		while (exp_q.size() > 0 && got.size() > 0)
			check(got.pop_front(), exp_q.pop_front());
		got.delete();
		exp_q.delete();
		#1;
	endtask
	initial begin
		void'($urandom(32'h42A37B5A));
		repeat (19) @(posedge core_clk);
		#1;
		check({in_ready, out_valid, auto_adj_busy, flags, code, mon_out}, 32'h1000_0000);
		for (int i = 0; i < 3; i++)
			check(now[i], 0);
		@(posedge core_clk);
		rst <= 1'b0;
		tc[0] <= 13'h1900;
		stall <= 1'b0;
		host.send(2'h0, 16'sh03E8);
		exp_q.push_back(18'h00000);
		drain();
		tc[0] <= 13'h0000;
		$display("test reset and filter done");
		for (int i = 0; i < 48; i++) begin
			@(posedge core_clk);
			sel <= 2'(i % 4);
			mon_in <= (i < 40) ? 15'(corner[i / 4]) : 15'($urandom_range(0, 32767));
			@(posedge core_clk);
			#1 check(mon_out, mon_exp(i % 4, mon_in));
		end
		$display("test monitor done");
		write_ofs(6000, -400, 400);
		write_ofs(-6000, 400, -400);
		write_ofs(5578, -342, 342);
		write_ofs(-3, 5, 0);
		$display("test offsets done");
		stall <= 1'b1;
		fork
			for (int i = 0; i < 24; i++)
				put(i % 4, $urandom_range(0, 40000) - 20000);
			begin
				repeat (40) @(negedge core_clk);
				check(in_ready, 0);
				stall <= 1'b0;
			end
		join
		drain();
		slow <= 1'b1;
		for (int i = 0; i < 12; i++)
			put($urandom_range(0, 3), $urandom_range(0, 40000) - 20000);
		drain();
		slow <= 1'b0;
		$display("test sample path done");
		for (int i = 0; i < 10; i++) begin
			@(posedge core_clk);
			for (int j = 0; j < 3; j++)
				lvl[j] <= (j == atab[i][0]) ? 7'(atab[i][1]) : 7'h00;
			alarm_clear <= 1'b1;
			@(posedge core_clk);
			alarm_clear <= 1'b0;
			write_ofs(atab[i][2], atab[i][2], atab[i][2]);
			put(atab[i][0], atab[i][3]);
			drain();
			check(flags, atab[i][4] << atab[i][0]);
			check(code, atab[i][4] ? `AIC_ALARM_EXCESS : `AIC_ALARM_NONE);
		end
		$display("test alarm done");
		@(posedge core_clk);
		auto_adj_start <= 1'b1;
		@(posedge core_clk);
		auto_adj_start <= 1'b0;
		#1 check(auto_adj_busy, 1);
		// host holds 0 V; what arrives is the converter's own error
		host.send(2'h0, 16'sh01F4);
		host.send(2'h1, -16'sh0014);
		host.send(2'h2, 16'sh0190);
		host.idle();
		for (n = 0; auto_adj_done !== 1'b1 && n < 200; n++)
			@(negedge core_clk);
		check({auto_adj_done, auto_adj_busy}, 2'b10);
		cur = '{500, -20, 342};
		for (int i = 0; i < 3; i++)
			check(now[i], cur[i]);
		repeat (10) @(posedge core_clk);
		got.delete();
		put(0, 600);
		drain();
		$display("test auto adjust done");
		conclude();
	end
endmodule
`default_nettype wire
